// ### rtl/onoff_ctrl.sv
// on/off control decision, output polarity and auto-tune gating
module onoff_ctrl
	import onoff_pkg::*;
#(
	parameter int HOLD_CYCLES = HOLD_CYC,
	parameter int KEY_CYCLES = KEY_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// process and operator
	input wire logic [15:0] process_value_i,
	input wire logic [1:0] event_sel_i,
	input wire logic run_i,
	input wire logic key_change_i,
	input wire logic key_confirm_i,
	input wire logic [15:0] key_value_i,
	// auxiliary functions and tuning engine
	input wire logic [2:0] aux_func_i,
	input wire onoff_heater_s heater_i,
	input wire logic tune_done_i,
	input wire onoff_pid_s tune_result_i,
	// outputs
	output logic [2:0] aux_out_o,
	output onoff_heater_s heater_out_o,
	output logic [2:0] aux_indicator_o,
	output logic heat_out_o,
	output logic cool_out_o,
	output logic [15:0] set_point_o,
	output logic at_active_o,
	output logic at_full_o,
	output logic self_tune_start_o
);
	logic [31:0] cfg;
	logic [15:0] sp_bank [4];
	logic [15:0] heating_hysteresis;
	logic [15:0] cooling_hysteresis;
	logic [15:0] deadband_width;
	logic [1:0] auto_tune;
	onoff_pid_s pid;
	onoff_at_e at_state;
	logic [31:0] hold_cnt;
	logic powered;
	logic [31:0] key_cnt;
	logic key_pend;
	logic [15:0] key_val;
	logic started;
	logic [15:0] last_sp;
	logic heat_state;
	logic cool_state;
	logic wr;
	logic [1:0] prot;
	logic [1:0] sp_idx;
	logic [15:0] next_sp;
	logic signed [17:0] pv_s;
	logic signed [17:0] sp_s;
	logic signed [17:0] db_s;
	logic signed [17:0] h_off;
	logic signed [17:0] h_on;
	logic signed [17:0] c_off;
	logic signed [17:0] c_on;
	logic signed [17:0] d_on;
	logic key_commit;

	// byte-lane merge of a 32-bit write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// signed add widened by two bits so thresholds do not wrap
	function automatic logic signed [17:0] add_s(input logic [15:0] a, input logic [15:0] b,
		input logic neg);
		logic signed [17:0] r;
		r = neg ? ($signed({2'b00, a}) - $signed({2'b00, b}))
			: ($signed({2'b00, a}) + $signed({2'b00, b}));
		return r;
	endfunction

	assign wr = cyc_i && stb_i && we_i && !ack_o;
	assign prot = cfg[CFG_PROT_LO +: 2];
	// four-point bank uses both event bits, two-point only the low one
	assign sp_idx = cfg[CFG_FOURSP] ? event_sel_i : {1'b0, event_sel_i[0]};
	assign next_sp = sp_bank[sp_idx];
	// one decode shared by the bank write and the key timer
	assign key_commit = key_pend && (key_confirm_i || key_cnt >= KEY_CYCLES - 1);

	// single-cycle ack, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
		end
	end

	// read mux, registered; unmapped offsets read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (cyc_i && stb_i && !we_i && !ack_o) begin
			case (adr_i)
				OFS_CFG: dat_o <= cfg;
				OFS_SP0: dat_o <= {16'h0000, sp_bank[0]};
				OFS_SP1: dat_o <= {16'h0000, sp_bank[1]};
				OFS_SP2: dat_o <= {16'h0000, sp_bank[2]};
				OFS_SP3: dat_o <= {16'h0000, sp_bank[3]};
				OFS_HYS: dat_o <= {cooling_hysteresis, heating_hysteresis};
				OFS_DB: dat_o <= {16'h0000, deadband_width};
				OFS_AT: dat_o <= {30'h0000_0000, auto_tune};
				OFS_PID: dat_o <= {pid.der_time, pid.prop_band};
				OFS_KEYSP: dat_o <= {16'h0000, pid.int_time};
				OFS_STAT: dat_o <= {11'h000, heat_state, cool_state, powered, key_pend,
					at_state == AT_RUN, set_point_o};
				default: dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// configuration and tuning parameters
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg <= CFG_RESET;
			heating_hysteresis <= HYS_RESET;
			cooling_hysteresis <= HYS_RESET;
			deadband_width <= 16'h0000;
		end else if (wr) begin
			case (adr_i)
				OFS_CFG: cfg <= merge(cfg, dat_i, sel_i);
				OFS_HYS: {cooling_hysteresis, heating_hysteresis} <=
					merge({cooling_hysteresis, heating_hysteresis}, dat_i, sel_i);
				OFS_DB: deadband_width <= dat_i[15:0];
				default: ;
			endcase
		end
	end

	// set point bank; bus and keyed entry both blocked by protection level 3
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 4; i++) begin
				sp_bank[i] <= 16'h0000;
			end
		end else if (prot != PROT_NO_SP) begin
			if (key_commit) begin
				sp_bank[sp_idx] <= key_val;
			end else if (wr && adr_i >= OFS_SP0 && adr_i <= OFS_SP3) begin
				sp_bank[2'(adr_i[4:2] - 3'h1)] <= dat_i[15:0];
			end
		end
	end

	// keyed entry: restart idle timer on each key
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			key_pend <= 1'b0;
			key_cnt <= 32'h0;
			key_val <= 16'h0000;
		end else if (key_change_i) begin
			key_pend <= 1'b1;
			key_cnt <= 32'h0;
			key_val <= key_value_i;
		end else if (key_pend) begin
			if (key_commit) begin
				key_pend <= 1'b0;
			end
			key_cnt <= key_cnt + 32'h1;
		end
	end

	// power-up hold of alarm outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_cnt <= 32'h0;
			powered <= 1'b0;
		end else if (!powered) begin
			hold_cnt <= hold_cnt + 32'h1;
			powered <= (hold_cnt >= HOLD_CYCLES - 1);
		end
	end

	// output polarity; aux and heater outputs forced off until the hold ends, indicators follow the functions
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux_out_o <= 3'h0;
			heater_out_o <= '0;
			aux_indicator_o <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				aux_out_o[i] <= powered && (aux_func_i[i] ^ cfg[CFG_OPEN0 + i]);
			end
			heater_out_o <= powered ? (heater_i ^ {4{cfg[CFG_OPEN0]}}) : '0;
			aux_indicator_o <= aux_func_i;
		end
	end

	assign set_point_o = next_sp;

	// thresholds widened by two bits so that subtraction near zero cannot wrap
	always_comb begin
		pv_s = $signed({2'b00, process_value_i});
		sp_s = $signed({2'b00, next_sp});
		// dead band shifts whichever side it sits on away from set point
		db_s = cfg[CFG_HEATCOOL] ? $signed({2'b00, deadband_width}) : 18'sh00000;
		h_off = cfg[CFG_DBCOOL] ? sp_s : sp_s - db_s;
		c_off = cfg[CFG_DBCOOL] ? sp_s + db_s : sp_s;
		h_on = h_off - $signed({2'b00, heating_hysteresis});
		c_on = c_off + $signed({2'b00, cooling_hysteresis});
		d_on = add_s(next_sp, heating_hysteresis, 1'b0);
	end

	// on/off comparators with hold inside the band; pid mode or stop forces both off
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i || cfg[CFG_PIDSEL]) begin
			heat_state <= 1'b0;
			cool_state <= 1'b0;
		end else if (!cfg[CFG_HEATCOOL]) begin
			cool_state <= 1'b0;
			// reverse acts as heater, direct as cooler, same heating band
			if (!cfg[CFG_DIRECT]) begin
				if (pv_s >= sp_s) begin
					heat_state <= 1'b0;
				end else if (pv_s <= h_on) begin
					heat_state <= 1'b1;
				end
			end else begin
				if (pv_s <= sp_s) begin
					heat_state <= 1'b0;
				end else if (pv_s >= d_on) begin
					heat_state <= 1'b1;
				end
			end
		end else begin
			if (pv_s >= h_off) begin
				heat_state <= 1'b0;
			end else if (pv_s <= h_on) begin
				heat_state <= 1'b1;
			end
			if (pv_s <= c_off) begin
				cool_state <= 1'b0;
			end else if (pv_s >= c_on) begin
				cool_state <= 1'b1;
			end
		end
	end

	assign heat_out_o = heat_state;
	assign cool_out_o = cool_state;

	// auto-tune command and state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			auto_tune <= AT_OFF;
			at_state <= AT_IDLE;
		end else begin
			case (at_state)
				AT_IDLE: begin
					if (wr && adr_i == OFS_AT && run_i && cfg[CFG_PIDSEL]
						&& (dat_i[1:0] == AT_FULL
						|| (dat_i[1:0] == AT_REDUCED && !cfg[CFG_HEATCOOL]))) begin
						auto_tune <= dat_i[1:0];
						at_state <= AT_RUN;
					end
				end
				AT_RUN: begin
					if ((wr && adr_i == OFS_AT && dat_i[1:0] == AT_OFF) || !run_i) begin
						auto_tune <= AT_OFF;
						at_state <= AT_IDLE;
					end else if (tune_done_i) begin
						at_state <= AT_DONE;
					end
				end
				AT_DONE: begin
					auto_tune <= AT_OFF;
					at_state <= AT_IDLE;
				end
				default: at_state <= AT_IDLE;
			endcase
		end
	end

	assign at_active_o = (at_state == AT_RUN);
	assign at_full_o = (auto_tune == AT_FULL);

	// pid constants: bus writes or tuning result
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pid <= '0;
		end else if (tune_done_i && (at_state == AT_RUN || (cfg[CFG_ST_EN] && cfg[CFG_PIDSEL]))) begin
			pid <= tune_result_i;
		end else if (wr && adr_i == OFS_PID) begin
			pid.prop_band <= dat_i[15:0];
			pid.der_time <= dat_i[31:16];
		end else if (wr && adr_i == OFS_KEYSP) begin
			pid.int_time <= dat_i[15:0];
		end
	end

	// self-tune trigger on first run and each set point change
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			started <= 1'b0;
			last_sp <= 16'h0000;
			self_tune_start_o <= 1'b0;
		end else begin
			self_tune_start_o <= cfg[CFG_ST_EN] && cfg[CFG_PIDSEL] && run_i
				&& (!started || next_sp != last_sp);
			if (run_i) begin
				started <= 1'b1;
				last_sp <= next_sp;
			end
		end
	end
endmodule

// ### rtl/onoff_pkg.sv
// shared constants, register map and types for the on/off control output block
package onoff_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_SP0 = 8'h04;
	localparam logic [7:0] OFS_SP1 = 8'h08;
	localparam logic [7:0] OFS_SP2 = 8'h0C;
	localparam logic [7:0] OFS_SP3 = 8'h10;
	localparam logic [7:0] OFS_HYS = 8'h14;
	localparam logic [7:0] OFS_DB = 8'h18;
	localparam logic [7:0] OFS_AT = 8'h1C;
	localparam logic [7:0] OFS_PID = 8'h20;
	localparam logic [7:0] OFS_KEYSP = 8'h24;
	localparam logic [7:0] OFS_STAT = 8'h28;
	// cfg field positions
	localparam int CFG_OPEN0 = 0;
	localparam int CFG_HEATCOOL = 3;
	localparam int CFG_PIDSEL = 4;
	localparam int CFG_DIRECT = 5;
	localparam int CFG_DBCOOL = 6;
	localparam int CFG_FOURSP = 7;
	localparam int CFG_ST_EN = 8;
	localparam int CFG_PROT_LO = 12;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [1:0] PROT_NO_SP = 2'h3;
	// power-on value of both hysteresis fields
	localparam logic [15:0] HYS_RESET = 16'h0008;
	// auto-tune command codes
	localparam logic [1:0] AT_OFF = 2'h0;
	localparam logic [1:0] AT_REDUCED = 2'h1;
	localparam logic [1:0] AT_FULL = 2'h2;
	// timing
	localparam int CLK_HZ = 40_000_000;
	localparam int HOLD_MS = 2000;
	localparam int KEY_MS = 2000;
	localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
	localparam int KEY_CYC = CLK_HZ / 1000 * KEY_MS;
	// auxiliary function inputs that share output 1 inversion
	typedef struct packed {
		logic burnout;
		logic short_alarm;
		logic overcurrent;
		logic input_error;
	} onoff_heater_s;
	// tuning result
	typedef struct packed {
		logic [15:0] prop_band;
		logic [15:0] int_time;
		logic [15:0] der_time;
	} onoff_pid_s;
	typedef enum logic [2:0] {
		AT_IDLE = 3'b001,
		AT_RUN = 3'b010,
		AT_DONE = 3'b100
	} onoff_at_e;
endpackage

// ### verification/onoff_ctrl_props.sv
// concurrent checks on the ports of the on/off control output block
module onoff_ctrl_props
	import onoff_pkg::*;
#(
	parameter int HOLD_CYCLES = 20
) (
	// clock, reset and bus handshake
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// functions and results
	input wire logic run_i,
	input wire logic [2:0] aux_func_i,
	input wire onoff_heater_s heater_i,
	input wire logic tune_done_i,
	input wire logic [2:0] aux_out_o,
	input wire onoff_heater_s heater_out_o,
	input wire logic [2:0] aux_indicator_o,
	input wire logic heat_out_o,
	input wire logic cool_out_o,
	input wire logic at_active_o
);
	int cnt;
	logic settled;
	// cycles since reset release, saturating so it never wraps
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 0;
		end else if (cnt < HOLD_CYCLES + 4) begin
			cnt <= cnt + 1;
		end
	end
	assign settled = cnt >= HOLD_CYCLES + 3;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_quiet;
		settled && !$past(ack_o) && !$past(ack_o, 2);
	endsequence
	a_ack_after_req: assert property (s_req |=> ack_o)
		else $error("no ack one cycle after request");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_hold_alarm_off: assert property (cnt < HOLD_CYCLES - 1 |-> aux_out_o == 3'h0)
		else $error("alarm output on during power-up hold");
	a_indicator_func: assert property (
		!$past(rst_i) |-> aux_indicator_o == $past(aux_func_i))
		else $error("indicator does not follow function");
	a_polarity_fixed: assert property (
		s_quiet |-> $stable(aux_out_o ^ aux_indicator_o))
		else $error("output polarity changed without write");
	a_heater_invert: assert property (s_quiet |->
		heater_out_o == ($past(heater_i) ^ {4{aux_out_o[0] ^ aux_indicator_o[0]}}))
		else $error("heater outputs not following output one polarity");
	a_done_clears: assert property (tune_done_i && at_active_o |-> ##[1:2] !at_active_o)
		else $error("tuning still active after done");
	a_stop_cancels: assert property (!$past(run_i) |-> !at_active_o)
		else $error("tuning active while stopped");
	a_outputs_excl: assert property (!(heat_out_o && cool_out_o))
		else $error("heating and cooling both on");
endmodule
bind onoff_ctrl onoff_ctrl_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (.clk_i, .rst_i, .cyc_i,
	.stb_i, .ack_o, .run_i, .aux_func_i, .heater_i, .tune_done_i, .aux_out_o, .heater_out_o,
	.aux_indicator_o, .heat_out_o, .cool_out_o, .at_active_o);

// ### verification/onoff_ctrl_tb.sv
// self-checking bench for the on/off control output block
module onoff_ctrl_tb
	import onoff_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, run_i = 0;
	logic key_change_i = 0, key_confirm_i = 0, tune_done_i = 0, ack_o;
	logic heat_out_o, cool_out_o, at_active_o, at_full_o, self_tune_start_o;
	logic [7:0] adr_i = 0;
	logic [3:0] sel_i = 0;
	logic [31:0] dat_i = 0, dat_o, rd;
	logic [15:0] process_value_i = 0, key_value_i = 0, set_point_o;
	logic [1:0] event_sel_i = 0;
	logic [2:0] aux_func_i = 3'h5, aux_out_o, aux_indicator_o;
	onoff_heater_s heater_i = 4'hA, heater_out_o;
	onoff_pid_s tune_result_i = '0;
	int fail_count = 0, cmp_count = 0;
	// short hold and key timeouts keep the run brief
	onoff_ctrl #(.HOLD_CYCLES(20), .KEY_CYCLES(20)) dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
		.adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .process_value_i, .event_sel_i, .run_i,
		.key_change_i, .key_confirm_i, .key_value_i, .aux_func_i, .heater_i, .tune_done_i,
		.tune_result_i, .aux_out_o, .heater_out_o, .aux_indicator_o, .heat_out_o, .cool_out_o,
		.set_point_o, .at_active_o, .at_full_o, .self_tune_start_o);
	initial forever #12.5 clk_i = ~clk_i;
	task give_verdict;
		$display("checks %0d errors %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task w(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	// one classic cycle, held until ack is sampled high
	task wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1; stb_i <= 1; we_i <= wr; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			give_verdict;
		end
		rd = dat_o;
		cyc_i <= 0; stb_i <= 0; we_i <= 0;
	endtask
	task t_reset;
		w(2);
		chk("aux_hold", 3'h0, aux_out_o);
		chk("ind", 3'h5, aux_indicator_o);
		wb(0, OFS_CFG, 0); chk("cfg", CFG_RESET, rd);
		wb(0, OFS_HYS, 0); chk("hys", 32'h0008_0008, rd);
		wb(0, 8'h3C, 0); chk("unmapped", 32'h0, rd);
		w(30);
		chk("aux_close", 3'h5, aux_out_o);
		chk("heat_close", 4'hA, heater_out_o);
	endtask
	task t_pol;
		wb(1, OFS_CFG, 32'h1); w(2);
		chk("aux_open0", 3'h4, aux_out_o);
		chk("heat_open", 4'h5, heater_out_o);
		chk("ind_open", 3'h5, aux_indicator_o);
		wb(1, OFS_CFG, 32'h2); w(2);
		chk("aux_open1", 3'h7, aux_out_o);
		chk("heat_c", 4'hA, heater_out_o);
	endtask
	task t_sp;
		wb(1, OFS_SP0, 32'h0064); wb(1, OFS_CFG, 32'h3000); wb(1, OFS_SP0, 32'h00C8);
		wb(0, OFS_SP0, 0); chk("sp_prot", 32'h0064, rd);
		wb(1, OFS_CFG, 32'h80);
		for (int k = 1; k < 4; k++) wb(1, OFS_SP0 + 8'(4 * k), 32'(100 + 256 * k));
		for (int k = 0; k < 4; k++) begin
			event_sel_i <= 2'(k); w(2);
			chk("sp4", 32'(100 + 256 * k), {16'h0, set_point_o});
		end
		wb(1, OFS_CFG, 32'h0); event_sel_i <= 2'h2; w(2);
		chk("sp2", 32'h0064, {16'h0, set_point_o});
		event_sel_i <= 2'h0;
	endtask
	task t_onoff;
		logic [15:0] pv [12] = '{16'h0384, 16'h03E8, 16'h03E3, 16'h03D4, 16'h03E3, 16'h044C,
			16'h03E8, 16'h03ED, 16'h03FC, 16'h03ED, 16'h02BC, 16'h0514};
		logic [1:0] ex [12] = '{2'h1, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1,
			2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h1};
		logic [1:0] got;
		run_i <= 1;
		wb(1, OFS_SP0, 32'h03E8);
		for (int i = 0; i < 12; i++) begin
			if (i == 5) wb(1, OFS_CFG, 32'h20);
			if (i == 10) wb(1, OFS_CFG, 32'h08);
			process_value_i <= pv[i]; w(3);
			got = i < 10 ? {1'b0, heat_out_o | cool_out_o} : {heat_out_o, cool_out_o};
			chk("ctl", ex[i], got);
		end
		wb(1, OFS_CFG, 32'h0);
	endtask
	// heat/cool dead band on either side, cooling band narrower than heating
	task db(input logic [15:0] v, input logic [1:0] e);
		process_value_i <= v;
		w(3);
		chk("db", e, {heat_out_o, cool_out_o});
	endtask
	task t_db;
		wb(1, OFS_HYS, 32'h0004_0008);
		wb(1, OFS_DB, 32'h0014);
		wb(1, OFS_CFG, 32'h08);
		db(16'h03DE, 2'h0);
		db(16'h03EC, 2'h1);
		db(16'h03CA, 2'h2);
		db(16'h03D9, 2'h0);
		wb(1, OFS_CFG, 32'h48);
		db(16'h03F2, 2'h0);
		db(16'h0400, 2'h1);
		wb(1, OFS_CFG, 32'h0);
	endtask
	task t_key;
		key_value_i <= 16'h012C; key_change_i <= 1; w(1); key_change_i <= 0; w(3);
		key_confirm_i <= 1; w(1); key_confirm_i <= 0; w(3);
		chk("key_ok", 16'h012C, set_point_o);
		key_value_i <= 16'h0190; key_change_i <= 1; w(1); key_change_i <= 0; w(5);
		chk("key_wait", 16'h012C, set_point_o);
		w(25);
		chk("key_idle", 16'h0190, set_point_o);
		wb(0, OFS_STAT, 0);
		chk("stat", 32'h0004_0190, rd);
	endtask
	task at(input logic [31:0] c, input logic [1:0] e);
		wb(1, OFS_AT, c); w(2);
		chk("at", e, {at_active_o, at_full_o});
	endtask
	task t_at;
		at(AT_FULL, 2'h0);
		wb(1, OFS_CFG, 32'h10); run_i <= 0;
		at(AT_FULL, 2'h0);
		run_i <= 1;
		at(AT_FULL, 2'h3);
		tune_result_i <= {16'h0011, 16'h0022, 16'h0033};
		tune_done_i <= 1; w(1); tune_done_i <= 0; w(3);
		wb(0, OFS_AT, 0); chk("at_off", AT_OFF, rd);
		wb(0, OFS_PID, 0); chk("pd", 32'h0033_0011, rd);
		wb(0, OFS_KEYSP, 0); chk("i", 32'h0022, rd);
		at(AT_REDUCED, 2'h2);
		at(AT_OFF, 2'h0);
		wb(1, OFS_CFG, 32'h18);
		at(AT_REDUCED, 2'h0);
		at(AT_FULL, 2'h3);
	endtask
	// self-tune fires on a set point change, and on the first run after a reset
	task t_st;
		wb(1, OFS_CFG, 32'h110);
		w(1);
		chk("st_idle", 1'b0, self_tune_start_o);
		wb(1, OFS_SP0, 32'h0258);
		w(1);
		chk("st_sp", 1'b1, self_tune_start_o);
		w(1);
		chk("st_once", 1'b0, self_tune_start_o);
		rst_i <= 1;
		run_i <= 0;
		w(2);
		rst_i <= 0;
		w(2);
		chk("aux_rst", 3'h0, aux_out_o);
		wb(1, OFS_CFG, 32'h110);
		run_i <= 1;
		w(2);
		chk("st_first", 1'b1, self_tune_start_o);
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		t_reset; t_pol; t_sp; t_onoff; t_db; t_key; t_at; t_st;
		give_verdict;
	end
endmodule
